// file: shared/twm_regs.svh
// register indices, field positions, reset values and bus timing
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH
// word indices; byte address is four times the index
`define TWM_IDX_DATA     3'h0
`define TWM_IDX_STATUS   3'h1
`define TWM_IDX_CSTAT    3'h2
`define TWM_IDX_CTRL     3'h3
`define TWM_IDX_ADDR1    3'h4
`define TWM_IDX_ADDR2    3'h5
`define TWM_IDX_ENABLE   3'h6
// status_byte fields
`define TWM_ST_TXDIR     0
`define TWM_ST_MASTER    1
`define TWM_ST_NEWHIT    2
`define TWM_ST_SSTALL    3
`define TWM_ST_REFUSED   4
`define TWM_ST_BUSERR    5
`define TWM_ST_BUFSVC    6
// control_one fields
`define TWM_CT_START     0
`define TWM_CT_STOP      1
`define TWM_CT_IRQEN     2
`define TWM_CT_ENDRD     3
`define TWM_CT_ASTALL    4
`define TWM_CT_GCEN      5
`define TWM_CT_NHIRQEN   6
// control_status_byte fields
`define TWM_CS_BUSY      0
`define TWM_CS_HIT       1
`define TWM_CS_GCHIT     2
`define TWM_CS_KIND      3
// own address registers, enable bit, general call address and byte reset value
`define TWM_AD_VALID     7
`define TWM_EN_BIT       0
`define TWM_GC_ADDR      8'h00
`define TWM_BYTE_RST     8'h00
// timing
`define TWM_CLK_NS       10
`define TWM_SCL_HALF_NS  5000
`define TWM_HALF_CYC     (`TWM_SCL_HALF_NS / `TWM_CLK_NS)
`endif

// file: shared/twm_pkg.sv
// types shared by the two-wire controller
package twm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_STALL, ST_COND, ST_LOW, ST_HIGH
  } twm_state_e;
  typedef logic [7:0] twm_byte_t;
endpackage : twm_pkg

// file: logic/twm_ctrl.sv
// two-wire bus master and addressed slave with Avalon-MM registers
//
// How it works
// - start issued only when bus free
// - after start, hold SCL low
// - SCL pulled low early sets bus error
// - clean start sets master and service flags
// - interrupt on error or service after start
// - address byte sent, ack stored as refused
// - SDA mismatch aborts, error, master cleared
// - address-only stall sets stall flag, holds SCL
// - acked transmit address requests next byte
// - acked receive address starts first byte
// - interrupt on bus error or refused
// - refused data byte leaves service flag clear
// - end-of-read bit answers last byte negatively
// - stop request sends stop, self-clears
// - SCL held low while stall bits set
// - misplaced start/stop gives error, clears master
// - enabled and not master means slave
// - address compared after every start
// - hit acked, hit flags set, service set on read hits
// - new-hit interrupt needs both enables
// - data shifts most significant bit first
// - all-zero address byte is general call
// - status clears on reset or disable
`timescale 1ns/10ps
`include "twm_regs.svh"
module twm_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output twm_pkg::twm_byte_t readdata8,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sclOut,
  output logic             sclOe,
  output logic             sdaOut,
  output logic             sdaOe
);
  import twm_pkg::*;

  twm_state_e state_q;
  logic       en_q, irqEn_q, endRd_q, addrStallEn_q, gcEn_q, newHitIrqEn_q;
  logic [7:0] addr1_q, addr2_q, shift_q, rxByte_q, monShift_q;
  logic       sclS1_q, sclS2_q, sclP_q, sdaS1_q, sdaS2_q, sdaP_q;
  logic [9:0] div_q;
  logic [3:0] bitCnt_q, monCnt_q;
  logic       mstSda_q, mstScl_q, slvSda_q, slvAck_q, isStop_q;
  logic       addrPhase_q, addrNext_q, txPend_q, rxNext_q;
  logic       start_q, stop_q, busErr_q, master_q, bufSvc_q, refused_q;
  logic       startStall_q, txDir_q, newHit_q, busy_q;
  logic       afterStart_q, hit_q, gcHit_q, kind_q, hitEv_q, hitRw_q;
  logic [7:0] statusByte, cstatByte, ctrlByte;

  // ******************************************************
  // register bus decode
  // ******************************************************
  wire logic busReq  = read | write;
  wire logic wrEn    = write & ~waitrequest;
  wire logic rdEn    = read & ~waitrequest;
  wire logic wrData  = wrEn && address == `TWM_IDX_DATA;
  wire logic rdData  = rdEn && address == `TWM_IDX_DATA;
  wire logic wrStat  = wrEn && address == `TWM_IDX_STATUS;
  wire logic wrCstat = wrEn && address == `TWM_IDX_CSTAT;
  wire logic wrCtrl  = wrEn && address == `TWM_IDX_CTRL;
  wire logic [7:0] readMux =
    address == `TWM_IDX_DATA   ? rxByte_q   :
    address == `TWM_IDX_STATUS ? statusByte :
    address == `TWM_IDX_CSTAT  ? cstatByte  :
    address == `TWM_IDX_CTRL   ? ctrlByte   :
    address == `TWM_IDX_ADDR1  ? addr1_q    :
    address == `TWM_IDX_ADDR2  ? addr2_q    :
    address == `TWM_IDX_ENABLE ? {7'h00, en_q} : 8'h00;

  always_comb begin
    statusByte = `TWM_BYTE_RST;
    statusByte[`TWM_ST_TXDIR]   = txDir_q;
    statusByte[`TWM_ST_MASTER]  = master_q;
    statusByte[`TWM_ST_NEWHIT]  = newHit_q;
    statusByte[`TWM_ST_SSTALL]  = startStall_q;
    statusByte[`TWM_ST_REFUSED] = refused_q;
    statusByte[`TWM_ST_BUSERR]  = busErr_q;
    statusByte[`TWM_ST_BUFSVC]  = bufSvc_q;
    cstatByte = `TWM_BYTE_RST;
    cstatByte[`TWM_CS_BUSY]  = busy_q;
    cstatByte[`TWM_CS_HIT]   = hit_q;
    cstatByte[`TWM_CS_GCHIT] = gcHit_q;
    cstatByte[`TWM_CS_KIND]  = kind_q;
    ctrlByte = `TWM_BYTE_RST;
    ctrlByte[`TWM_CT_START]   = start_q;
    ctrlByte[`TWM_CT_STOP]    = stop_q;
    ctrlByte[`TWM_CT_IRQEN]   = irqEn_q;
    ctrlByte[`TWM_CT_ENDRD]   = endRd_q;
    ctrlByte[`TWM_CT_ASTALL]  = addrStallEn_q;
    ctrlByte[`TWM_CT_GCEN]    = gcEn_q;
    ctrlByte[`TWM_CT_NHIRQEN] = newHitIrqEn_q;
  end

  // answer one cycle after the request is seen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      readdata8   <= 8'h00;
    end else begin
      waitrequest <= ~(busReq & waitrequest);
      if (busReq & waitrequest) begin
        readdata  <= {24'h00_0000, readMux};
        readdata8 <= readMux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_q          <= 1'b0;
      irqEn_q       <= 1'b0;
      endRd_q       <= 1'b0;
      addrStallEn_q <= 1'b0;
      gcEn_q        <= 1'b0;
      newHitIrqEn_q <= 1'b0;
      addr1_q       <= `TWM_BYTE_RST;
      addr2_q       <= `TWM_BYTE_RST;
    end else begin
      if (wrCtrl) begin
        irqEn_q       <= writedata[`TWM_CT_IRQEN];
        endRd_q       <= writedata[`TWM_CT_ENDRD];
        addrStallEn_q <= writedata[`TWM_CT_ASTALL];
        gcEn_q        <= writedata[`TWM_CT_GCEN];
        newHitIrqEn_q <= writedata[`TWM_CT_NHIRQEN];
      end
      if (wrEn && address == `TWM_IDX_ADDR1) addr1_q <= writedata[7:0];
      if (wrEn && address == `TWM_IDX_ADDR2) addr2_q <= writedata[7:0];
      if (wrEn && address == `TWM_IDX_ENABLE) en_q <= writedata[`TWM_EN_BIT];
    end
  end

  // ******************************************************
  // pin synchronisers and bus monitor
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {sclS1_q, sclS2_q, sclP_q} <= 3'h7;
      {sdaS1_q, sdaS2_q, sdaP_q} <= 3'h7;
    end else begin
      {sclS1_q, sclS2_q, sclP_q} <= {sclIn, sclS1_q, sclS2_q};
      {sdaS1_q, sdaS2_q, sdaP_q} <= {sdaIn, sdaS1_q, sdaS2_q};
    end
  end

  wire logic startDet = sclS2_q & sclP_q & sdaP_q & ~sdaS2_q;
  wire logic stopDet  = sclS2_q & sclP_q & ~sdaP_q & sdaS2_q;
  wire logic sclRise  = sclS2_q & ~sclP_q;
  wire logic sclFall  = ~sclS2_q & sclP_q;
  // a stop or repeated start sits in the high phase of the first clock
  // after a byte, so only conditions from the second clock on are illegal
  wire logic illegal  = (startDet | stopDet) & (monCnt_q > 4'h1);
  wire logic [7:0] monByte = {monShift_q[6:0], sdaS2_q};
  wire logic own1 = addr1_q[`TWM_AD_VALID] && monByte[7:1] == addr1_q[6:0];
  wire logic own2 = addr2_q[`TWM_AD_VALID] && monByte[7:1] == addr2_q[6:0];
  wire logic gcNow  = gcEn_q && monByte == `TWM_GC_ADDR;
  wire logic anyHit = own1 | own2 | gcNow;

  // slave side runs whether or not this end is master
  always_ff @(posedge sys_clk) begin
    if (reset | ~en_q) begin
      busy_q <= 1'b0;
      monCnt_q <= 4'h0;
      monShift_q <= 8'h00;
      {afterStart_q, slvAck_q, slvSda_q, hitEv_q, hitRw_q} <= 5'h00;
      {hit_q, gcHit_q, kind_q} <= 3'h0;
    end else begin
      hitEv_q <= 1'b0;
      if (wrCstat && writedata[`TWM_CS_BUSY]) busy_q <= 1'b0;
      if (startDet | stopDet) begin
        busy_q       <= startDet;
        monCnt_q     <= 4'h0;
        afterStart_q <= startDet;
        slvAck_q     <= 1'b0;
        slvSda_q     <= 1'b0;
        if (illegal) {hit_q, gcHit_q} <= 2'h0;
      end else if (sclRise && monCnt_q < 4'h9) begin
        monShift_q <= monByte;
        monCnt_q   <= monCnt_q + 4'h1;
        if (monCnt_q == 4'h7 && afterStart_q) begin
          afterStart_q <= 1'b0;
          if (anyHit) begin
            slvAck_q <= 1'b1;
            hitEv_q  <= 1'b1;
            hitRw_q  <= monByte[0];
            hit_q    <= 1'b1;
            gcHit_q  <= gcNow;
            kind_q   <= own2;
          end
        end
      end else if (sclFall) begin
        if (monCnt_q == 4'h8) slvSda_q <= slvAck_q;
        else if (monCnt_q == 4'h9) begin
          monCnt_q <= 4'h0;
          slvSda_q <= 1'b0;
          slvAck_q <= 1'b0;
        end
      end
    end
  end

  // ******************************************************
  // master engine and status flags
  // ******************************************************
  wire logic halfDone  = div_q == 10'(`TWM_HALF_CYC - 1);
  wire logic stallBits = refused_q | bufSvc_q | (addrStallEn_q & startStall_q);
  wire logic txMode    = addrPhase_q | txDir_q;
  wire logic bitDrive  = (bitCnt_q < 4'h8) ? (txMode & ~shift_q[7])
                                           : (~txMode & ~endRd_q);
  wire logic loseArb   = state_q == ST_HIGH && sclS2_q && txMode
                         && bitCnt_q < 4'h8 && !mstSda_q && !sdaS2_q;
  wire logic ackDone   = state_q == ST_HIGH && sclS2_q && halfDone
                         && bitCnt_q == 4'h8;

  always_ff @(posedge sys_clk) begin
    if (reset | ~en_q) begin
      state_q <= ST_IDLE;
      div_q <= 10'h000;
      bitCnt_q <= 4'h0;
      {shift_q, rxByte_q} <= 16'h0000;
      {mstSda_q, mstScl_q, isStop_q, start_q, stop_q} <= 5'h00;
      {addrPhase_q, addrNext_q, txPend_q, rxNext_q} <= 4'h0;
      {busErr_q, master_q, bufSvc_q, refused_q} <= 4'h0;
      {startStall_q, txDir_q, newHit_q} <= 3'h0;
    end else begin
      div_q <= halfDone ? 10'h000 : div_q + 10'h001;
      // software clears first so that hardware sets below win
      if (wrCtrl) begin
        start_q <= writedata[`TWM_CT_START];
        stop_q  <= writedata[`TWM_CT_STOP];
      end
      if (wrStat) begin
        busErr_q     <= busErr_q & ~writedata[`TWM_ST_BUSERR];
        refused_q    <= refused_q & ~writedata[`TWM_ST_REFUSED];
        startStall_q <= startStall_q & ~writedata[`TWM_ST_SSTALL];
        newHit_q     <= newHit_q & ~writedata[`TWM_ST_NEWHIT];
      end
      if (wrData) begin
        shift_q  <= writedata[7:0];
        txPend_q <= 1'b1;
        bufSvc_q <= 1'b0;
      end
      if (rdData) begin
        bufSvc_q <= 1'b0;
        if (master_q & ~txDir_q & ~start_q) rxNext_q <= 1'b1;
      end
      if (hitEv_q) begin
        newHit_q <= 1'b1;
        if (!master_q) txDir_q <= hitRw_q;
        if (hitRw_q) bufSvc_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          div_q <= 10'h000;
          if (start_q && !busy_q && !master_q) begin
            mstSda_q <= 1'b1;
            state_q  <= ST_START;
          end
        end
        ST_START: begin
          if (!sclS2_q) begin
            busErr_q <= 1'b1;
            mstSda_q <= 1'b0;
            start_q  <= 1'b0;
            state_q  <= ST_IDLE;
          end else if (halfDone) begin
            mstScl_q   <= 1'b1;
            master_q   <= 1'b1;
            bufSvc_q   <= 1'b1;
            start_q    <= 1'b0;
            addrNext_q <= 1'b1;
            state_q    <= ST_STALL;
          end
        end
        ST_STALL: begin
          mstScl_q <= 1'b1;
          div_q    <= 10'h000;
          bitCnt_q <= 4'h0;
          if (!stallBits && stop_q) begin
            mstSda_q <= 1'b1;
            isStop_q <= 1'b1;
            rxNext_q <= 1'b0;
            state_q  <= ST_COND;
          end else if (!stallBits && txPend_q) begin
            txPend_q   <= 1'b0;
            rxNext_q   <= 1'b0;
            addrNext_q <= 1'b0;
            if (start_q) begin
              isStop_q <= 1'b0;
              state_q  <= ST_COND;
            end else begin
              addrPhase_q <= addrNext_q;
              if (addrNext_q) txDir_q <= ~shift_q[0];
              state_q <= ST_LOW;
            end
          end else if (!stallBits && rxNext_q) begin
            rxNext_q <= 1'b0;
            state_q  <= ST_LOW;
          end
        end
        // repeated start or stop: release SCL, then move SDA
        ST_COND: begin
          if (bitCnt_q == 4'h1 && !sclS2_q) div_q <= 10'h000;
          else if (halfDone) begin
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h0) mstScl_q <= 1'b0;
            else if (bitCnt_q == 4'h1) mstSda_q <= ~isStop_q;
            else if (isStop_q) begin
              master_q <= 1'b0;
              stop_q   <= 1'b0;
              state_q  <= ST_IDLE;
            end else begin
              mstScl_q    <= 1'b1;
              start_q     <= 1'b0;
              addrPhase_q <= 1'b1;
              txDir_q     <= ~shift_q[0];
              bitCnt_q    <= 4'h0;
              state_q     <= ST_LOW;
            end
          end
        end
        ST_LOW: begin
          mstSda_q <= bitDrive;
          if (halfDone) begin
            mstScl_q <= 1'b0;
            state_q  <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (!sclS2_q) div_q <= 10'h000;
          else if (halfDone && bitCnt_q < 4'h8) begin
            mstScl_q <= 1'b1;
            shift_q  <= {shift_q[6:0], sdaS2_q};
            bitCnt_q <= bitCnt_q + 4'h1;
            state_q  <= ST_LOW;
          end else if (ackDone) begin
            mstScl_q    <= 1'b1;
            mstSda_q    <= 1'b0;
            addrPhase_q <= 1'b0;
            state_q     <= ST_STALL;
            if (txMode) begin
              refused_q <= sdaS2_q;
              if (!sdaS2_q) begin
                if (addrPhase_q && addrStallEn_q) startStall_q <= 1'b1;
                else if (addrPhase_q && !txDir_q) rxNext_q <= 1'b1;
                else bufSvc_q <= 1'b1;
              end
            end else begin
              rxByte_q <= shift_q;
              bufSvc_q <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (loseArb | illegal) begin
        busErr_q <= 1'b1;
        master_q <= 1'b0;
        mstSda_q <= 1'b0;
        mstScl_q <= 1'b0;
        state_q  <= ST_IDLE;
      end
    end
  end

  // open-drain pins: the output level is always low, enables drive
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {sdaOe, sclOe, sdaOut, sclOut, irq} <= 5'h00;
    end else begin
      sdaOe <= mstSda_q | slvSda_q;
      sclOe <= mstScl_q;
      irq   <= irqEn_q & (busErr_q | bufSvc_q | refused_q
               | (addrStallEn_q & startStall_q)
               | (newHitIrqEn_q & newHit_q));
    end
  end

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || !en_q);

  AST_START_FREE: assert property (
    $rose(state_q == ST_START) |-> $past(!busy_q && start_q))
    else $error("start issued on a busy bus");
  AST_START_HOLD: assert property (
    (state_q == ST_STALL)[*2] |-> sclOe)
    else $error("SCL not held low in stall");
  AST_EARLY_SCL: assert property (
    state_q == ST_START && !sclS2_q |=> busErr_q && !master_q)
    else $error("early SCL did not flag bus error");
  AST_MASTER_SVC: assert property (
    $rose(master_q) |-> bufSvc_q && $past(state_q == ST_START))
    else $error("master set without service flag");
  AST_ACK_STORE: assert property (
    ackDone && txMode |=> refused_q == $past(sdaS2_q))
    else $error("ack level not stored");
  AST_ARB_LOSS: assert property (
    loseArb |=> busErr_q && !master_q && state_q == ST_IDLE)
    else $error("lost arbitration not handled");
  AST_ADDR_STALL: assert property (
    ackDone && addrPhase_q && addrStallEn_q && !sdaS2_q
    |=> startStall_q ##1 sclOe)
    else $error("address-only stall missing");
  AST_IRQ_ERR: assert property (
    irqEn_q && (busErr_q || refused_q) |=> irq)
    else $error("interrupt missing on error");
  AST_NACK_LAST: assert property (
    state_q == ST_LOW && bitCnt_q == 4'h8 && !txMode && endRd_q
    |=> !mstSda_q)
    else $error("last byte was acknowledged");
  AST_STOP_CLR: assert property (
    $fell(master_q) && $past(state_q == ST_COND) |-> !stop_q)
    else $error("stop request not cleared");
  AST_STALL_HOLD: assert property (
    state_q == ST_STALL && stallBits && !illegal |=> state_q == ST_STALL)
    else $error("stall left with stall bits set");
  AST_SLV_ACK: assert property (
    sclFall && monCnt_q == 4'h8 && slvAck_q |=> ##1 sdaOe)
    else $error("slave hit not acknowledged");
  AST_NOIRQ: assert property (
    !irqEn_q |=> !irq)
    else $error("interrupt without enable");
  AST_DISABLED: assert property (@(posedge sys_clk) disable iff (reset)
    !en_q |=> statusByte == 8'h00)
    else $error("status not cleared while disabled");

  COV_START: cover property ($rose(master_q));
  COV_NACK: cover property (ackDone && txMode && sdaS2_q);
  COV_HIT: cover property (hitEv_q);
  COV_STOP: cover property ($fell(master_q) && !busErr_q);
endmodule : twm_ctrl

// file: testbench/twm_slave_model.sv
// behavioural slave on the two-wire bus: acks its address, may refuse data
`timescale 1ns/10ps
module twm_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h50
) (
  input  wire logic          scl,
  input  wire logic          sda,
  input  wire logic          refuseData,
  output logic               sdaPull,
  output twm_pkg::twm_byte_t lastByte,
  output logic [3:0]         byteCount,
  output logic               stopSeen
);
  import twm_pkg::*;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic       inFrame;
  logic       addrByte, readDir;
  initial begin
    addrByte = 1'b0;
    readDir = 1'b0;
    sdaPull = 1'b0;
    lastByte = 8'h00;
    byteCount = 4'h0;
    stopSeen = 1'b0;
    bitCnt = 4'h0;
    shiftIn = 8'h00;
    inFrame = 1'b0;
  end
  // ****************
  // frame tracking
  // ****************
  always @(negedge sda) if (scl === 1'b1) begin
    inFrame = 1'b1;
    addrByte = 1'b1;
    bitCnt = 4'h0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    inFrame = 1'b0;
    stopSeen = 1'b1;
  end
  always @(posedge scl) if (inFrame && bitCnt < 4'h8) begin
    shiftIn = {shiftIn[6:0], sda};
    bitCnt = bitCnt + 4'h1;
  end
  // released line floats to the pull-up level, never a held value
  always @(negedge scl) if (inFrame) begin
    if (bitCnt == 4'h8) begin
      lastByte = shiftIn;
      byteCount = byteCount + 4'h1;
      // first byte after any start is an address; never ack own reads
      sdaPull = addrByte ? (shiftIn[7:1] == SLV_ADDR)
                         : (!refuseData && !readDir);
      if (addrByte) readDir = shiftIn[0];
      addrByte = 1'b0;
      bitCnt = 4'h9;
    end else if (bitCnt == 4'h9) begin
      sdaPull = 1'b0;
      bitCnt = 4'h0;
    end
  end
endmodule : twm_slave_model

// file: testbench/testbench.sv
// self-checking bench: master start, address, refused data, stop
`timescale 1ns/10ps
`include "twm_regs.svh"
module testbench;
  import twm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  address = 3'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        refuseData = 1'b0;
  twm_byte_t   readdata8, lastByte;
  logic [31:0] readdata;
  logic        waitrequest, irq, sclOut, sclOe, sdaOut, sdaOe;
  logic        slvPull, stopSeen;
  logic [3:0]  byteCount;
  wire         sclLine = ~sclOe;
  wire         sdaLine = ~(sdaOe | slvPull);
  int          num_errors = 0;
  int          n_compared = 0;

  always #5 sys_clk = ~sys_clk;

  twm_ctrl twm_ctrl_inst (.sys_clk(sys_clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata8(readdata8), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
  twm_slave_model twm_slave_model_inst (.scl(sclLine), .sda(sdaLine),
    .refuseData(refuseData), .sdaPull(slvPull), .lastByte(lastByte),
    .byteCount(byteCount), .stopSeen(stopSeen));

  // ****************
  // tasks
  // ****************
  task conclude;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task cmpByte(input twm_byte_t got, input twm_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpByte
  task cmpBit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpBit
  // request held until the edge that samples waitrequest low
  task busCycle(input logic [2:0] idx, input logic wr, input twm_byte_t wd,
                output twm_byte_t rdv);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= idx;
    read <= ~wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    rdv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : busCycle
  task wr(input logic [2:0] idx, input twm_byte_t d);
    twm_byte_t dummy;
    busCycle(idx, 1'b1, d, dummy);
  endtask : wr
  task rdc(input logic [2:0] idx, input twm_byte_t exp);
    twm_byte_t r;
    busCycle(idx, 1'b0, 8'h00, r);
    cmpByte(r, exp);
  endtask : rdc
  task waitBit(input logic [2:0] idx, input int b, input logic v);
    twm_byte_t r;
    int n;
    n = 0;
    do begin
      busCycle(idx, 1'b0, 8'h00, r);
      n++;
    end while (r[b] !== v && n < 8000);
    cmpBit(r[b], v);
  endtask : waitBit

  // ****************
  // tests
  // ****************
  initial begin
    repeat (80000) @(posedge sys_clk);
    num_errors++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(`TWM_IDX_STATUS, 8'h00);
    rdc(`TWM_IDX_CSTAT, 8'h00);
    rdc(3'h7, 8'h00);
    wr(`TWM_IDX_ENABLE, 8'h01);
    wr(`TWM_IDX_CTRL, 8'h05);
    waitBit(`TWM_IDX_STATUS, `TWM_ST_MASTER, 1'b1);
    rdc(`TWM_IDX_STATUS, 8'h42);
    cmpByte(readdata8, 8'h42);
    cmpBit(sclOe, 1'b1);
    cmpBit(irq, 1'b1);
    wr(`TWM_IDX_DATA, 8'hA0);
    waitBit(`TWM_IDX_STATUS, `TWM_ST_BUFSVC, 1'b1);
    rdc(`TWM_IDX_STATUS, 8'h43);
    cmpByte(lastByte, 8'hA0);
    cmpBit(sclOe, 1'b1);
    refuseData <= 1'b1;
    wr(`TWM_IDX_DATA, 8'h5A);
    waitBit(`TWM_IDX_STATUS, `TWM_ST_REFUSED, 1'b1);
    rdc(`TWM_IDX_STATUS, 8'h13);
    cmpByte(lastByte, 8'h5A);
    cmpBit(irq, 1'b1);
    refuseData <= 1'b0;
    wr(`TWM_IDX_CTRL, 8'h0D);
    wr(`TWM_IDX_DATA, 8'hA1);
    wr(`TWM_IDX_STATUS, 8'h10);
    waitBit(`TWM_IDX_STATUS, `TWM_ST_BUFSVC, 1'b1);
    rdc(`TWM_IDX_STATUS, 8'h42);
    wr(`TWM_IDX_CTRL, 8'h06);
    rdc(`TWM_IDX_DATA, 8'hFF);
    waitBit(`TWM_IDX_CTRL, `TWM_CT_STOP, 1'b0);
    waitBit(`TWM_IDX_STATUS, `TWM_ST_MASTER, 1'b0);
    for (int i = 0; i < 3000 && !stopSeen; i++) @(posedge sys_clk);
    cmpBit(stopSeen, 1'b1);
    cmpBit(sclOe, 1'b0);
    wr(`TWM_IDX_CSTAT, 8'h01);
    rdc(`TWM_IDX_CSTAT, 8'h00);
    wr(`TWM_IDX_ENABLE, 8'h00);
    rdc(`TWM_IDX_STATUS, 8'h00);
    conclude;
  end
endmodule : testbench
